// ===== bench/host_axi_master.sv
module host_axi_master (
   // Clock
   input wire logic aclk,
   // Write channels
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // Address and data offered together, each dropped once taken
   task automatic write(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
      bit aw;
      bit w;
      aw = 1;
      w = 1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= 3'h7;
      repeat (100) begin
         @(posedge aclk);
         if (aw && awready) begin
            aw = 0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 0;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            return;
         end
      end
      tb_software_strap_config_latch.fail_count++;
      tb_software_strap_config_latch.end_of_test();
   endtask
   task automatic read(input logic [11:0] a, output logic [31:0] d,
                       output logic [1:0] r);
      bit ar;
      ar = 1;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      repeat (100) begin
         @(posedge aclk);
         if (ar && arready) begin
            ar = 0;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            return;
         end
      end
      tb_software_strap_config_latch.fail_count++;
      tb_software_strap_config_latch.end_of_test();
   endtask
endmodule

// ===== bench/tb_software_strap_config_latch.sv
module tb_software_strap_config_latch;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irst, sdone, xover, aneg;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, mode, r;
   int fail_count, tests_run, pulses;
   localparam logic [11:0] strap = strap_pkg::addr_soft_strap;
   software_strap_config_latch software_strap_config_latch_i (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .internal_reset(irst), .reset_sequence_done(sdone),
      .crossover_auto_on(xover), .autoneg_on(aneg),
      .negotiation_mode_select(mode));
   host_axi_master host_axi_master_i (.aclk(aclk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d, checks %0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Strap outputs seen as one word: rst, done, xover, aneg, mode
   task automatic outs(input logic [5:0] exp);
      @(negedge aclk);
      check(32'({irst, sdone, xover, aneg, mode}), 32'(exp));
   endtask
   initial begin
      aclk = 0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      aresetn = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      host_axi_master_i.read(strap, d, r);
      check(d, 32'h7800);
      outs(6'h0f);
      host_axi_master_i.write(strap, 32'h0800, r);
      check(32'(r), 32'(strap_pkg::resp_okay));
      repeat (8) @(posedge aclk);
      outs(6'h0f);
      host_axi_master_i.read(strap, d, r);
      check(d, 32'h0800);
      host_axi_master_i.write(strap, 32'h8800, r);
      pulses = 0;
      repeat (20) begin
         @(negedge aclk);
         if (irst === 1'b1)
            pulses++;
      end
      check(pulses, strap_pkg::pulse_cycles);
      outs(6'h11);
      // Done cleared: sequence waits again, straps held
      host_axi_master_i.write(strap, 32'h4000, r);
      repeat (4) @(posedge aclk);
      outs(6'h01);
      host_axi_master_i.write(strap, 32'hc000, r);
      repeat (20) @(posedge aclk);
      outs(6'h18);
      // Status writes are ignored, unmapped ones refused
      host_axi_master_i.write(strap_pkg::addr_status, 32'h0, r);
      check(32'(r), 32'(strap_pkg::resp_okay));
      host_axi_master_i.write(12'h030, 32'hffff, r);
      check(32'(r), 32'(strap_pkg::resp_slverr));
      outs(6'h18);
      host_axi_master_i.read(strap_pkg::addr_status, d, r);
      check(d, 32'h28);
      host_axi_master_i.read(12'h030, d, r);
      check(32'(r), 32'(strap_pkg::resp_slverr));
      check(d, 32'h0);
      // Second reset in mid-run: straps back to defaults
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      outs(6'h0f);
      host_axi_master_i.read(strap, d, r);
      check(d, 32'h7800);
      end_of_test();
   end
endmodule

// ===== rtl/reset_pulse_gen.sv
module reset_pulse_gen #(
   parameter int width = strap_pkg::pulse_cycles
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Trigger and pulse
   input wire logic start,
   output logic pulse
);
   typedef struct packed {
      logic [7:0] count;
      logic pulse;
   } pulse_state_type;
   pulse_state_type state;
   pulse_state_type next_state;
   always_comb begin
      next_state = state;
      if (start) begin
         next_state.count = 8'(width);
         next_state.pulse = 1'b1;
      end else if (state.count != 8'h00) begin
         next_state.count = state.count - 8'h01;
         next_state.pulse = (state.count != 8'h01);
      end else begin
         next_state.pulse = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign pulse = state.pulse;
endmodule

// ===== rtl/software_strap_config_latch.sv
module software_strap_config_latch (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Latched strap controls
   output logic internal_reset,
   output logic reset_sequence_done,
   output logic crossover_auto_on,
   output logic autoneg_on,
   output logic [1:0] negotiation_mode_select
);
   typedef struct packed {
      logic aw_held;
      logic [11:0] aw_addr;
      logic w_held;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [15:0] strap;
      strap_pkg::seq_state_type seq;
      logic start;
      logic rst_out;
      logic done_out;
      logic xover;
      logic aneg;
      logic [1:0] mode;
      logic awready;
      logic wready;
      logic arready;
      logic [7:0] rst_len;
   } latch_state_type;
   latch_state_type state;
   latch_state_type next_state;
   logic pulse;

   reset_pulse_gen #(.width(strap_pkg::pulse_cycles)) reset_pulse_gen_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(state.start),
      .pulse(pulse)
   );

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] data, input logic [1:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) r[7:0] = data[7:0];
      if (strb[1]) r[15:8] = data[15:8];
      return r & strap_pkg::strap_mask;
   endfunction

   function automatic logic addr_hit(input logic [11:0] addr,
      input logic [11:0] base);
      return addr[11:2] == base[11:2];
   endfunction

   always_comb begin
      next_state = state;
      next_state.start = 1'b0;
      if (s_axi_awvalid && !state.aw_held) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state.w_held) begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata[15:0];
         next_state.w_strb = s_axi_wstrb[1:0];
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      if (state.aw_held && state.w_held && !state.bvalid) begin
         next_state.aw_held = 1'b0;
         next_state.w_held = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = strap_pkg::resp_okay;
         if (addr_hit(state.aw_addr, strap_pkg::addr_soft_strap)) begin
            next_state.strap = merge(state.strap, state.w_data, state.w_strb);
            if (next_state.strap[strap_pkg::done_bit]
                && !state.strap[strap_pkg::done_bit]) begin
               next_state.start = 1'b1;
            end
         end else if (!addr_hit(state.aw_addr, strap_pkg::addr_status)) begin
            next_state.bresp = strap_pkg::resp_slverr;
         end
      end
      if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !state.rvalid) begin
         next_state.rvalid = 1'b1;
         next_state.rresp = strap_pkg::resp_okay;
         next_state.rdata = 32'h0000_0000;
         if (addr_hit(s_axi_araddr, strap_pkg::addr_soft_strap)) begin
            next_state.rdata[15:0] = state.strap;
         end else if (addr_hit(s_axi_araddr, strap_pkg::addr_status)) begin
            next_state.rdata[5:0] = {state.done_out, state.rst_out,
               state.xover, state.aneg, state.mode};
         end else begin
            next_state.rresp = strap_pkg::resp_slverr;
         end
      end
      case (state.seq)
         strap_pkg::seq_wait: begin
            if (state.start) begin
               next_state.seq = strap_pkg::seq_pulse;
            end
         end
         strap_pkg::seq_pulse: begin
            // Flag cleared mid-pulse: do not finish the sequence
            if (!pulse && state.strap[strap_pkg::done_bit]) begin
               next_state.seq = strap_pkg::seq_done;
            end else if (!pulse) begin
               next_state.seq = strap_pkg::seq_wait;
            end
         end
         strap_pkg::seq_done: begin
            if (!state.strap[strap_pkg::done_bit]) begin
               next_state.seq = strap_pkg::seq_wait;
            end
         end
         default: next_state.seq = strap_pkg::seq_wait;
      endcase
      next_state.rst_out = pulse;
      if (state.start) begin
         next_state.xover = state.strap[strap_pkg::crossover_bit];
         next_state.aneg = state.strap[strap_pkg::autoneg_bit];
         next_state.mode = state.strap[strap_pkg::mode_high_bit:
            strap_pkg::mode_low_bit];
      end
      next_state.done_out = (next_state.seq == strap_pkg::seq_done);
      // Cycles of pulse so far, for the length checks below
      next_state.rst_len = next_state.rst_out ? state.rst_len + 8'h01 : 8'h00;
      // Ready kept in flops so the ports carry no gate
      next_state.awready = !next_state.aw_held;
      next_state.wready = !next_state.w_held;
      next_state.arready = !next_state.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
         state.awready <= 1'b1;
         state.wready <= 1'b1;
         state.arready <= 1'b1;
         state.strap <= strap_pkg::strap_reset;
         state.seq <= strap_pkg::seq_wait;
         state.xover <= strap_pkg::strap_reset[strap_pkg::crossover_bit];
         state.aneg <= strap_pkg::strap_reset[strap_pkg::autoneg_bit];
         state.mode <= strap_pkg::strap_reset[strap_pkg::mode_high_bit:
            strap_pkg::mode_low_bit];
      end else begin
         state <= next_state;
      end
   end

   assign s_axi_awready = state.awready;
   assign s_axi_wready = state.wready;
   assign s_axi_bvalid = state.bvalid;
   assign s_axi_bresp = state.bresp;
   assign s_axi_arready = state.arready;
   assign s_axi_rvalid = state.rvalid;
   assign s_axi_rresp = state.rresp;
   assign s_axi_rdata = state.rdata;
   assign internal_reset = state.rst_out;
   assign reset_sequence_done = state.done_out;
   assign crossover_auto_on = state.xover;
   assign autoneg_on = state.aneg;
   assign negotiation_mode_select = state.mode;

   property p_capture;
      @(posedge aclk) disable iff (!aresetn)
      state.start |=> (crossover_auto_on == $past(state.strap[14])
         && autoneg_on == $past(state.strap[13]));
   endproperty
   a_capture: assert property (p_capture)
      else $error("strap capture wrong");

   property p_pulse;
      @(posedge aclk) disable iff (!aresetn)
      state.start |-> ##[2:3] internal_reset;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("no reset pulse");

   property p_gate;
      @(posedge aclk) disable iff (!aresetn)
      !state.strap[15] |=> !reset_sequence_done;
   endproperty
   a_gate: assert property (p_gate)
      else $error("done without flag");

   property p_mode;
      @(posedge aclk) disable iff (!aresetn)
      state.start |=> negotiation_mode_select == $past(state.strap[12:11]);
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode not captured");

   property p_stable;
      @(posedge aclk) disable iff (!aresetn)
      !state.start |=> $stable(crossover_auto_on);
   endproperty
   a_stable: assert property (p_stable)
      else $error("crossover changed");

   // Capture starts only on a fresh 0 to 1 of the flag
   property p_start_rise;
      @(posedge aclk) disable iff (!aresetn)
      state.start |-> (state.strap[strap_pkg::done_bit]
         && !$past(state.strap[strap_pkg::done_bit]));
   endproperty
   a_start_rise: assert property (p_start_rise)
      else $error("capture without flag rise");

   property p_start_one;
      @(posedge aclk) disable iff (!aresetn)
      state.start |=> !state.start;
   endproperty
   a_start_one: assert property (p_start_one)
      else $error("capture strobe too long");

   property p_rst_after_start;
      @(posedge aclk) disable iff (!aresetn)
      $rose(internal_reset) |-> $past(state.start, 2);
   endproperty
   a_rst_after_start: assert property (p_rst_after_start)
      else $error("reset pulse without capture");

   // A cut pulse would leave the core half reset
   property p_pulse_len;
      @(posedge aclk) disable iff (!aresetn)
      $fell(internal_reset)
         |-> $past(state.rst_len) == 8'(strap_pkg::pulse_cycles);
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pulse too short");

   property p_pulse_max;
      @(posedge aclk) disable iff (!aresetn)
      internal_reset |-> state.rst_len <= 8'(strap_pkg::pulse_cycles);
   endproperty
   a_pulse_max: assert property (p_pulse_max)
      else $error("reset pulse too long");

   property p_done_after;
      @(posedge aclk) disable iff (!aresetn)
      $rose(reset_sequence_done) |-> $fell(internal_reset);
   endproperty
   a_done_after: assert property (p_done_after)
      else $error("done before pulse end");

   property p_rst_no_done;
      @(posedge aclk) disable iff (!aresetn)
      internal_reset |-> !reset_sequence_done;
   endproperty
   a_rst_no_done: assert property (p_rst_no_done)
      else $error("done during reset pulse");

   // Checked through reset, so no disable here
   property p_flag_reset;
      @(posedge aclk)
      !aresetn |=> (!state.strap[strap_pkg::done_bit]
         && !reset_sequence_done && !internal_reset);
   endproperty
   a_flag_reset: assert property (p_flag_reset)
      else $error("flag not cleared by reset");

   property p_aneg_stable;
      @(posedge aclk) disable iff (!aresetn)
      !state.start |=> ($stable(autoneg_on)
         && $stable(negotiation_mode_select));
   endproperty
   a_aneg_stable: assert property (p_aneg_stable)
      else $error("autoneg or mode changed");
endmodule

// ===== rtl/strap_pkg.sv
package strap_pkg;
   // Register index; the bus byte address is four times it
   localparam logic [11:0] soft_strap_index = 12'h009;
   localparam logic [11:0] addr_soft_strap = {soft_strap_index[9:0], 2'h0};
   localparam logic [11:0] addr_status = 12'h028;
   localparam int done_bit = 15;
   localparam int crossover_bit = 14;
   localparam int autoneg_bit = 13;
   localparam int mode_high_bit = 12;
   localparam int mode_low_bit = 11;
   localparam logic [15:0] strap_reset = 16'h7800;
   localparam logic [15:0] strap_mask = 16'hf800;
   localparam int pulse_ns = 200;
   localparam int clk_ns = 50;
   localparam int pulse_cycles = (pulse_ns + clk_ns - 1) / clk_ns;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   typedef enum logic [1:0] {
      seq_wait = 2'h0,
      seq_pulse = 2'h1,
      seq_done = 2'h3
   } seq_state_type;
endpackage
